// ### hw/i2c_master_rx_ack_stop_arbitration.v
// Two-wire bus master: reception, acknowledge, stop, start and arbitration with an APB register port.
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "i2c_master_defines.vh"

module i2c_master_rx_ack_stop_arbitration (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        scl_in,
	output reg         scl_out,
	output reg         scl_oe,
	input  wire        sda_in,
	output reg         sda_out,
	output reg         sda_oe,
	output reg         wake_req
);

localparam S_IDLE  = 6'h01;
localparam S_START = 6'h02;
localparam S_TX    = 6'h04;
localparam S_RX    = 6'h08;
localparam S_ACK   = 6'h10;
localparam S_STOP  = 6'h20;

reg        scl_m;
reg        scl_s;
reg        sda_m;
reg        sda_s;
reg        sda_d;
reg  [5:0] state;
reg  [2:0] ph;
reg  [3:0] bitcnt;
reg  [7:0] shift_register;
reg  [7:0] transfer_buffer;
reg  [6:0] baud_reload_value;
reg  [6:0] baud_generator;
reg        module_enable;
reg        start_enable;
reg        stop_enable;
reg        receive_enable_bit;
reg        ack_sequence_enable;
reg        ack_data_value;
reg        ack_status;
reg        wake_enable;
reg        buffer_full;
reg        receive_overflow;
reg        write_collision;
reg        port_event_flag;
reg        bus_collision_flag;
reg        begin_condition_flag;
reg        end_condition_flag;

wire       acc;
wire       wr_acc;
wire       rd_acc;
wire       tmo;
wire       start_det;
wire       stop_det;
wire       coll;
wire       is_idle;

////////////////////////////////////////////////////////////////////////////////

// Only the second flip-flop of each synchroniser feeds logic, plus the third data flip-flop sda_d for start and stop detection.
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		scl_m <= 1'b1;
		scl_s <= 1'b1;
		sda_m <= 1'b1;
		sda_s <= 1'b1;
		sda_d <= 1'b1;
	end else begin
		scl_m <= scl_in;
		scl_s <= scl_m;
		sda_m <= sda_in;
		sda_s <= sda_m;
		sda_d <= sda_s;
	end
end

assign acc       = psel & penable & pready;
assign wr_acc    = acc & pwrite;
assign rd_acc    = acc & ~pwrite;
assign tmo       = (baud_generator == 7'h00);
assign start_det = scl_s & sda_d & ~sda_s;
assign stop_det  = scl_s & ~sda_d & sda_s;
assign is_idle   = (state == S_IDLE);

// Collision cases of start, byte, acknowledge and stop in one term.
assign coll = ((state == S_START) & (ph == 3'd0) & (~sda_s | ~scl_s)) |
	((state == S_START) & (ph == 3'd1) & sda_s & ~scl_s) |
	((state == S_TX) & (ph == 3'd2) & (bitcnt < `LAST_TX_BIT) & ~sda_oe & ~sda_s) |
	((state == S_ACK) & (ph == 3'd2) & ~sda_oe & ~sda_s) |
	((state == S_STOP) & (ph == 3'd3) & ~scl_s);

////////////////////////////////////////////////////////////////////////////////

// APB slave with one wait state so that read data comes from a flip-flop.
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pready  <= 1'b0;
		pslverr <= 1'b0;
		prdata  <= 32'h00000000;
	end else begin
		pready <= psel & penable & ~pready;
		if (psel & penable & ~pready) begin
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
			case (paddr)
			`CTRL_OFFSET: begin
				prdata[`CTRL_START]      <= start_enable;
				prdata[`CTRL_STOP]       <= stop_enable;
				prdata[`CTRL_RECEIVE]    <= receive_enable_bit;
				prdata[`CTRL_ACK_SEQ]    <= ack_sequence_enable;
				prdata[`CTRL_ACK_DATA]   <= ack_data_value;
				prdata[`CTRL_ACK_STATUS] <= ack_status;
				prdata[`CTRL_ENABLE]     <= module_enable;
				prdata[`CTRL_WAKE]       <= wake_enable;
			end
			`STATUS_OFFSET: begin
				prdata[`STAT_FULL]     <= buffer_full;
				prdata[`STAT_OVERFLOW] <= receive_overflow;
				prdata[`STAT_WRITE_COLLISION]     <= write_collision;
				prdata[`STAT_EVENT]    <= port_event_flag;
				prdata[`STAT_BUS_COLL] <= bus_collision_flag;
				prdata[`STAT_BEGIN]    <= begin_condition_flag;
				prdata[`STAT_END]      <= end_condition_flag;
			end
			`BUFFER_OFFSET: begin
				prdata[7:0] <= transfer_buffer;
			end
			`BAUD_OFFSET: begin
				prdata[6:0] <= baud_reload_value;
			end
			default: begin
				pslverr <= 1'b1;
			end
			endcase
		end
	end
end

// The processor wakes only for events it asked for; the port runs on in sleep.
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		wake_req <= 1'b0;
		scl_out  <= 1'b0;
		sda_out  <= 1'b0;
	end else begin
		wake_req <= port_event_flag & wake_enable;
		scl_out  <= 1'b0;
		sda_out  <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////

// Sequencer. Clears of sticky flags come first so that a later set in the same cycle wins.
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		state                <= S_IDLE;
		ph                   <= 3'd0;
		bitcnt               <= 4'h0;
		shift_register       <= 8'h00;
		transfer_buffer      <= 8'h00;
		baud_reload_value    <= `BAUD_RESET;
		baud_generator       <= 7'h00;
		module_enable        <= 1'b0;
		start_enable         <= 1'b0;
		stop_enable          <= 1'b0;
		receive_enable_bit   <= 1'b0;
		ack_sequence_enable  <= 1'b0;
		ack_data_value       <= 1'b0;
		ack_status           <= 1'b0;
		wake_enable          <= 1'b0;
		buffer_full          <= 1'b0;
		receive_overflow     <= 1'b0;
		write_collision      <= 1'b0;
		port_event_flag      <= 1'b0;
		bus_collision_flag   <= 1'b0;
		begin_condition_flag <= 1'b0;
		end_condition_flag   <= 1'b0;
		scl_oe               <= 1'b0;
		sda_oe               <= 1'b0;
	end else begin
		if (!tmo)
			baud_generator <= baud_generator - 7'h01;
		if (wr_acc && paddr == `CTRL_OFFSET) begin
			module_enable  <= pwdata[`CTRL_ENABLE];
			ack_data_value <= pwdata[`CTRL_ACK_DATA];
			wake_enable    <= pwdata[`CTRL_WAKE];
		end
		if (wr_acc && paddr == `BAUD_OFFSET)
			baud_reload_value <= pwdata[6:0];
		if (wr_acc && paddr == `STATUS_OFFSET) begin
			if (pwdata[`STAT_OVERFLOW])
				receive_overflow <= 1'b0;
			if (pwdata[`STAT_WRITE_COLLISION])
				write_collision <= 1'b0;
			if (pwdata[`STAT_EVENT])
				port_event_flag <= 1'b0;
			if (pwdata[`STAT_BUS_COLL])
				bus_collision_flag <= 1'b0;
		end
		if (rd_acc && paddr == `BUFFER_OFFSET)
			buffer_full <= 1'b0;
		if (wr_acc && paddr == `BUFFER_OFFSET && !is_idle)
			write_collision <= 1'b1;

		// Bus watcher runs whatever the sequencer does.
		if (!module_enable) begin
			begin_condition_flag <= 1'b0;
			end_condition_flag   <= 1'b0;
		end else if (start_det) begin
			begin_condition_flag <= 1'b1;
			end_condition_flag   <= 1'b0;
		end else if (stop_det) begin
			begin_condition_flag <= 1'b0;
			end_condition_flag   <= 1'b1;
			if (is_idle)
				port_event_flag <= 1'b1;
		end

		if (!module_enable) begin
			state               <= S_IDLE;
			scl_oe              <= 1'b0;
			sda_oe              <= 1'b0;
			start_enable        <= 1'b0;
			stop_enable         <= 1'b0;
			receive_enable_bit  <= 1'b0;
			ack_sequence_enable <= 1'b0;
		end else if (coll) begin
			bus_collision_flag  <= 1'b1;
			state               <= S_IDLE;
			scl_oe              <= 1'b0;
			sda_oe              <= 1'b0;
			start_enable        <= 1'b0;
			stop_enable         <= 1'b0;
			ack_sequence_enable <= 1'b0;
			if (state == S_TX)
				buffer_full <= 1'b0;
		end else begin
			case (state)
			S_IDLE: begin
				ph     <= 3'd0;
				bitcnt <= 4'h0;
				if (wr_acc && paddr == `CTRL_OFFSET) begin
					if (pwdata[`CTRL_START]) begin
						start_enable <= 1'b1;
						state        <= S_START;
					end else if (pwdata[`CTRL_STOP]) begin
						stop_enable <= 1'b1;
						sda_oe      <= 1'b1;
						state       <= S_STOP;
					end else if (pwdata[`CTRL_RECEIVE]) begin
						receive_enable_bit <= 1'b1;
						sda_oe             <= 1'b0;
						scl_oe             <= 1'b1;
						baud_generator     <= baud_reload_value;
						state              <= S_RX;
					end else if (pwdata[`CTRL_ACK_SEQ]) begin
						ack_sequence_enable <= 1'b1;
						scl_oe              <= 1'b1;
						sda_oe              <= ~pwdata[`CTRL_ACK_DATA];
						baud_generator      <= baud_reload_value;
						state               <= S_ACK;
					end
				end else if (wr_acc && paddr == `BUFFER_OFFSET) begin
					transfer_buffer <= pwdata[7:0];
					shift_register  <= pwdata[7:0];
					buffer_full     <= 1'b1;
					sda_oe          <= ~pwdata[7];
					scl_oe          <= 1'b1;
					baud_generator  <= baud_reload_value;
					state           <= S_TX;
				end
			end
			S_START: begin
				case (ph)
				3'd0: begin
					baud_generator <= baud_reload_value;
					ph             <= 3'd1;
				end
				3'd1: begin
					if (!sda_s || tmo) begin
						sda_oe         <= 1'b1;
						baud_generator <= baud_reload_value;
						ph             <= 3'd2;
					end
				end
				default: begin
					// A low clock here is another master's start and is not a collision.
					if (tmo) begin
						scl_oe          <= 1'b1;
						start_enable    <= 1'b0;
						port_event_flag <= 1'b1;
						state           <= S_IDLE;
					end
				end
				endcase
			end
			S_TX, S_RX, S_ACK: begin
				case (ph)
				3'd0: begin
					if (tmo) begin
						scl_oe <= 1'b0;
						ph     <= 3'd1;
					end
				end
				3'd1: begin
					// High time counts only once the clock is really high, so slaves may stretch it.
					if (scl_s) begin
						baud_generator <= baud_reload_value;
						ph             <= 3'd2;
						if (state == S_RX)
							shift_register <= {shift_register[6:0], sda_s};
						if (state == S_TX && bitcnt == `LAST_TX_BIT)
							ack_status <= sda_s;
					end
				end
				default: begin
					if (tmo) begin
						scl_oe         <= 1'b1;
						bitcnt         <= bitcnt + 4'h1;
						baud_generator <= baud_reload_value;
						ph             <= 3'd0;
						if (state == S_TX) begin
							if (bitcnt == `LAST_TX_BIT) begin
								port_event_flag <= 1'b1;
								state           <= S_IDLE;
							end else begin
								// Ones shifted in release data for the acknowledge slot.
								shift_register <= {shift_register[6:0], 1'b1};
								sda_oe         <= ~shift_register[6];
								if (bitcnt == `LAST_RX_BIT)
									buffer_full <= 1'b0;
							end
						end else if (state == S_RX) begin
							if (bitcnt == `LAST_RX_BIT) begin
								transfer_buffer    <= shift_register;
								buffer_full        <= 1'b1;
								if (buffer_full)
									receive_overflow <= 1'b1;
								port_event_flag    <= 1'b1;
								receive_enable_bit <= 1'b0;
								state              <= S_IDLE;
							end
						end else begin
							ack_sequence_enable <= 1'b0;
							port_event_flag     <= 1'b1;
							state               <= S_IDLE;
						end
					end
				end
				endcase
			end
			S_STOP: begin
				case (ph)
				3'd0: begin
					if (!sda_s) begin
						baud_generator <= baud_reload_value;
						ph             <= 3'd1;
					end
				end
				3'd1: begin
					if (tmo) begin
						scl_oe <= 1'b0;
						ph     <= 3'd2;
					end
				end
				3'd2: begin
					if (scl_s) begin
						baud_generator <= baud_reload_value;
						ph             <= 3'd3;
					end
				end
				3'd3: begin
					if (tmo) begin
						sda_oe <= 1'b0;
						ph     <= 3'd4;
					end
				end
				3'd4: begin
					if (sda_s && scl_s) begin
						baud_generator <= baud_reload_value;
						ph             <= 3'd5;
					end
				end
				default: begin
					if (tmo) begin
						stop_enable     <= 1'b0;
						port_event_flag <= 1'b1;
						state           <= S_IDLE;
					end
				end
				endcase
			end
			default: begin
				state <= S_IDLE;
			end
			endcase
		end
	end
end

endmodule

// ### hw/i2c_master_defines.vh
// Register offsets, field positions and reset values of the two-wire master port.
`ifndef I2C_MASTER_DEFINES_VH
`define I2C_MASTER_DEFINES_VH

`define CTRL_OFFSET      8'h00
`define STATUS_OFFSET    8'h04
`define BUFFER_OFFSET    8'h08
`define BAUD_OFFSET      8'h0C

`define CTRL_START       0
`define CTRL_STOP        2
`define CTRL_RECEIVE     3
`define CTRL_ACK_SEQ     4
`define CTRL_ACK_DATA    5
`define CTRL_ACK_STATUS  6
`define CTRL_ENABLE      7
`define CTRL_WAKE        8

`define STAT_FULL        0
`define STAT_OVERFLOW    1
`define STAT_WRITE_COLLISION        2
`define STAT_EVENT       3
`define STAT_BUS_COLL    4
`define STAT_BEGIN       5
`define STAT_END         6

`define BAUD_RESET       7'h09
`define LAST_TX_BIT      4'h8
`define LAST_RX_BIT      4'h7

`endif

// ### tb/i2c_master_rx_ack_stop_arbitration_chk.sv
// Port-level checker for the two-wire master port, bound to the design top.
`timescale 1ns/100ps
`include "i2c_master_defines.vh"

module i2c_master_rx_ack_stop_arbitration_chk (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        scl_in,
	input wire        scl_out,
	input wire        scl_oe,
	input wire        sda_in,
	input wire        sda_out,
	input wire        sda_oe,
	input wire        wake_req
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic write_collision_seen;
	logic wen;
	wire  done = psel && penable && pready;
	wire  st   = paddr == `STATUS_OFFSET;

	////////////////////////////////////////////////////////////////////////////////
	// Shadows of what software has seen and set, so stickiness can be judged.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			write_collision_seen <= 1'b0;
			wen       <= 1'b0;
		end else if (done) begin
			if (pwrite && st && pwdata[`STAT_WRITE_COLLISION])
				write_collision_seen <= 1'b0;
			else if (!pwrite && st && prdata[`STAT_WRITE_COLLISION])
				write_collision_seen <= 1'b1;
			if (pwrite && paddr == `CTRL_OFFSET)
				wen <= pwdata[`CTRL_WAKE];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	a_lines_low_only: assert property (!scl_out && !sda_out)
		else $error("line driven high");
	a_reset_release: assert property ($rose(presetn) |-> !scl_oe && !sda_oe && !pready)
		else $error("lines or bus busy right after reset");
	a_ready_one: assert property (psel && penable && !pready |=> pready ##1 !pready)
		else $error("access not answered with one wait state");
	a_unmapped_err: assert property (done |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}))
		else $error("error response wrong for address");
	a_write_collision_sticky: assert property (done && !pwrite && st && write_collision_seen |-> prdata[`STAT_WRITE_COLLISION])
		else $error("write collision flag cleared without software");
	a_wake_gate: assert property (!wen && !$past(wen) |-> !wake_req)
		else $error("wake raised while disabled");
	a_scl_low_hold: assert property ($rose(scl_oe) |=> scl_oe [*2])
		else $error("clock low phase too short");
	a_start_hold: assert property ($rose(sda_oe) && !scl_oe |=> !scl_oe [*2])
		else $error("clock pulled too soon after start");
	a_stop_order: assert property ($fell(sda_oe) && !scl_oe |-> $past(!scl_oe, 2))
		else $error("data released before clock in stop");

	c_start: cover property ($rose(sda_oe) && !scl_oe);
	c_buf_read: cover property (done && !pwrite && paddr == `BUFFER_OFFSET);
	c_wake: cover property (wake_req);
endmodule

bind i2c_master_rx_ack_stop_arbitration i2c_master_rx_ack_stop_arbitration_chk chk_u (.*);

// ### tb/i2c_slave_model.sv
// Behavioural far-side device: sends a byte, acknowledges, or holds data low.
`timescale 1ns/100ps

module i2c_slave_model (
	input  wire       scl,
	input  wire       arm,
	input  wire       rx_mode,
	input  wire       ack_low,
	input  wire       force_low,
	input  wire [7:0] tx_byte,
	output logic      sda_low
);
	int cnt;

	// Bit index advances on each falling clock; arm restarts the byte.
	always @(negedge scl or posedge arm) begin
		if (arm)
			cnt <= 0;
		else
			cnt <= cnt + 1;
	end

	// Only pulls low; the pull-up gives the high level and the released level.
	always_comb begin
		if (rx_mode)
			sda_low = force_low || (cnt < 8 && !tx_byte[3'd7 - cnt[2:0]]);
		else
			sda_low = force_low || (ack_low && cnt == 8);
	end
endmodule

// ### tb/i2c_master_rx_ack_stop_arbitration_tb_top.sv
// Register-level testbench of the two-wire master port with a far-side model.
`timescale 1ns/100ps
`include "i2c_master_defines.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
	$display("ERROR %0t: got %h expected %h", $time, g, e); end end

module i2c_master_rx_ack_stop_arbitration_tb_top;
	logic        pclk = 0;
	logic        presetn = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire         scl_oe;
	wire         sda_oe;
	wire         wake_req;
	wire         sda_low;
	logic        arm = 0;
	logic        rx_mode = 0;
	logic        ack_low = 0;
	logic        force_low = 0;
	logic [7:0]  tx_byte = 0;
	logic        rdy_s;
	logic        err_s;
	logic [31:0] rd_s;
	logic [31:0] rdv;
	logic        errv;
	int          n_errors = 0;
	int          check_count = 0;
	wire         scl = !scl_oe;
	wire         sda = !(sda_oe || sda_low);

	always #10 pclk = ~pclk;
	// Answer is captured mid-cycle so the edge that samples it never races the design.
	always @(negedge pclk) begin
		rdy_s <= pready;
		err_s <= pslverr;
		rd_s  <= prdata;
	end

	i2c_master_rx_ack_stop_arbitration dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .wake_req(wake_req));
	i2c_slave_model peer_u (.scl(scl), .arm(arm), .rx_mode(rx_mode), .ack_low(ack_low), .force_low(force_low),
		.tx_byte(tx_byte), .sda_low(sda_low));

	////////////////////////////////////////////////////////////////////////////////
	task automatic results;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (rdy_s === 1'b1 && penable) break;
		end
		if (i == 20) begin
			n_errors++;
			results();
		end
		rdv = rd_s;
		errv = err_s;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
		int i;
		for (i = 0; i < 200; i++) begin
			apb(0, a, 0);
			if (rdv[b] === v) break;
		end
		if (i == 200) begin
			n_errors++;
			results();
		end
	endtask

	task automatic rearm;
		@(posedge pclk);
		arm <= 1;
		@(posedge pclk);
		arm <= 0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		apb(0, `CTRL_OFFSET, 0); `CHK(rdv, 32'h00000000)
		apb(0, `BAUD_OFFSET, 0); `CHK(rdv[6:0], `BAUD_RESET)
		apb(0, `STATUS_OFFSET, 0); `CHK(rdv, 32'h00000000)
		apb(0, 8'h10, 0); `CHK(errv, 1'b1)
		apb(1, `BAUD_OFFSET, 32'h00000002);
		apb(1, `CTRL_OFFSET, 32'h00000180);
		apb(1, `CTRL_OFFSET, 32'h00000181);
		wait_bit(`CTRL_OFFSET, `CTRL_START, 0);
		apb(1, `STATUS_OFFSET, 32'h0000001F);
		// Transmit with and without acknowledge; a second write while shifting is refused.
		for (int k = 1; k >= 0; k--) begin
			ack_low <= k[0];
			rearm();
			apb(1, `BUFFER_OFFSET, 32'h0000005A);
			apb(1, `BUFFER_OFFSET, 32'h00000011);
			apb(1, `CTRL_OFFSET, 32'h00000188);
			apb(0, `CTRL_OFFSET, 0); `CHK(rdv[`CTRL_RECEIVE], 1'b0)
			wait_bit(`STATUS_OFFSET, `STAT_EVENT, 1);
			`CHK(wake_req, 1'b1)
			apb(0, `CTRL_OFFSET, 0); `CHK(rdv[`CTRL_ACK_STATUS], !k[0])
			apb(0, `STATUS_OFFSET, 0); `CHK(rdv[`STAT_WRITE_COLLISION], 1'b1)
			apb(1, `STATUS_OFFSET, 32'h0000000C);
		end
		rx_mode <= 1;
		tx_byte <= 8'hA5;
		rearm();
		apb(1, `CTRL_OFFSET, 32'h00000188);
		apb(1, `BUFFER_OFFSET, 0);
		wait_bit(`STATUS_OFFSET, `STAT_EVENT, 1);
		`CHK(rdv[2:0], 3'b101)
		apb(1, `STATUS_OFFSET, 32'h0000000C);
		tx_byte <= 8'h3C;
		rearm();
		apb(1, `CTRL_OFFSET, 32'h00000188);
		wait_bit(`STATUS_OFFSET, `STAT_EVENT, 1);
		`CHK(rdv[1:0], 2'b11)
		apb(0, `CTRL_OFFSET, 0); `CHK(rdv[`CTRL_RECEIVE], 1'b0)
		apb(0, `BUFFER_OFFSET, 0); `CHK(rdv[7:0], 8'h3C)
		apb(0, `STATUS_OFFSET, 0); `CHK(rdv[`STAT_FULL], 1'b0)
		rx_mode <= 0;
		// Not-acknowledge then acknowledge: data line follows the chosen value.
		for (int k = 1; k >= 0; k--) begin
			apb(1, `CTRL_OFFSET, 32'h00000190 | (k << 5));
			repeat (2) @(posedge pclk);
			@(negedge pclk); `CHK(sda_oe, !k[0])
			wait_bit(`CTRL_OFFSET, `CTRL_ACK_SEQ, 0);
		end
		apb(1, `STATUS_OFFSET, 32'h0000001F);
		apb(1, `CTRL_OFFSET, 32'h00000184);
		wait_bit(`CTRL_OFFSET, `CTRL_STOP, 0);
		apb(0, `STATUS_OFFSET, 0); `CHK(rdv[`STAT_END], 1'b1)
		`CHK(rdv[`STAT_EVENT], 1'b1)
		// A collision on a released one bit ends the byte and empties the buffer.
		apb(1, `CTRL_OFFSET, 32'h00000181);
		wait_bit(`CTRL_OFFSET, `CTRL_START, 0);
		apb(1, `STATUS_OFFSET, 32'h0000001F);
		apb(1, `BUFFER_OFFSET, 32'h000000FF);
		force_low <= 1;
		wait_bit(`STATUS_OFFSET, `STAT_BUS_COLL, 1);
		`CHK(rdv[`STAT_FULL], 1'b0)
		// With the port off no condition is seen, so both bus flags are clear for the claim.
		apb(1, `CTRL_OFFSET, 0);
		apb(1, `STATUS_OFFSET, 32'h0000001F);
		apb(1, `CTRL_OFFSET, 32'h00000180);
		apb(0, `STATUS_OFFSET, 0); `CHK(rdv[6:5], 2'b00)
		apb(1, `CTRL_OFFSET, 32'h00000181);
		wait_bit(`STATUS_OFFSET, `STAT_BUS_COLL, 1);
		apb(0, `CTRL_OFFSET, 0); `CHK(rdv[`CTRL_START], 1'b0)
		force_low <= 0;
		wait_bit(`STATUS_OFFSET, `STAT_EVENT, 1);
		`CHK(rdv[`STAT_END], 1'b1)
		apb(1, `CTRL_OFFSET, 0);
		apb(0, `STATUS_OFFSET, 0); `CHK(rdv[6:5], 2'b00)
		results();
	end
endmodule
